/* File: fe_amp_model.sv */
// behavioural model of the front-end amplifier chip on the control pins
`default_nettype none
module fe_amp_model (
  input wire logic mclk,
  input wire logic txEn,
  input wire logic rxEn,
  input wire logic bypassSel,
  input wire logic antSel,
  output var fe_ctrl_pkg::fe_mode_t feMode
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] pinsQ = 4'h0;
  int settleCnt = 0;
  fe_ctrl_pkg::fe_mode_t target;
  // ---------------------------------------------------------------
  // pin decode
  // ---------------------------------------------------------------
  // anything but txEn, rxEn or bypassSel alone (antSel low included) rests in shutdown
  always_comb begin
    case ({txEn, rxEn, bypassSel, antSel})
      4'h8: target = fe_ctrl_pkg::FRONT_END_TX_REQUEST;
      4'h4: target = fe_ctrl_pkg::FRONT_END_RX_REQUEST;
      4'h2: target = fe_ctrl_pkg::FRONT_END_PASSTHROUGH_REQUEST;
      default: target = fe_ctrl_pkg::FRONT_END_OFF_REQUEST;
    endcase
  end
  initial feMode = fe_ctrl_pkg::FRONT_END_OFF_REQUEST;
  // switch once the pins held still for 900 ns, inside the 1 us limit
  always @(posedge mclk) begin
    pinsQ <= {txEn, rxEn, bypassSel, antSel};
    if (pinsQ != {txEn, rxEn, bypassSel, antSel}) begin
      settleCnt <= 0;
    end else if (settleCnt < fe_ctrl_pkg::SETTLE_CYCLES - 3) begin
      settleCnt <= settleCnt + 1;
    end else begin
      feMode <= target;
    end
  end
endmodule : fe_amp_model
`default_nettype wire

/* File: fe_ctrl_pkg.sv */
// shared constants and types for the front-end mode controller
`default_nettype none
package fe_ctrl_pkg;
  // ---------------------------------------------------------------
  // register map (byte addresses, one word each)
  // ---------------------------------------------------------------
  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam logic [7:0] POWER_ADDR = 8'h04;
  localparam logic [7:0] STATUS_ADDR = 8'h08;
  localparam logic [7:0] APPLIED_ADDR = 8'h0C;
  // control word fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_STATIC_BIT = 2;
  localparam int CTRL_EU_BIT = 3;
  localparam int CTRL_CH26_BIT = 4;
  localparam int CTRL_DIR_BIT = 5;
  // ---------------------------------------------------------------
  // transmit power caps, two's complement dBm codes
  // ---------------------------------------------------------------
  localparam logic [7:0] CAP_AMERICA = 8'hF8;
  localparam logic [7:0] CAP_EUROPE = 8'hF0;
  localparam logic [7:0] CAP_CH26_BYPASS = 8'h06;
  localparam logic [7:0] POWER_RESET = 8'hF0;
  // link-enable mask of the two event links, loaded on a non-static change to tx, rx or passthrough and compared to gate events
  localparam logic [1:0] LINK_MASK = 2'h3;
  // ---------------------------------------------------------------
  // timing: front-end switch time against the 10 MHz clock
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int SWITCH_TIME_NS = 1000;
  localparam int SETTLE_CYCLES =
    (SWITCH_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_W = 4;
  // modes requested by software
  typedef enum logic [1:0] {
    FRONT_END_OFF_REQUEST = 2'h0,
    FRONT_END_TX_REQUEST = 2'h1,
    FRONT_END_RX_REQUEST = 2'h2,
    FRONT_END_PASSTHROUGH_REQUEST = 2'h3
  } fe_mode_t;
  // mode change sequencer
  typedef enum logic [4:0] {
    SEQ_IDLE = 5'h01,
    SEQ_LINK_OFF = 5'h02,
    SEQ_FORCE_LOW = 5'h04,
    SEQ_LOAD = 5'h08,
    SEQ_SETTLE = 5'h10
  } seq_t;
  // the four front-end control pins
  typedef struct packed {
    logic txEn;
    logic rxEn;
    logic bypassSel;
    logic antSel;
  } fe_pins_t;
  // apb request as seen by the slave
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;
endpackage : fe_ctrl_pkg
`default_nettype wire

/* File: fe_mode_ctrl.sv */
// front-end amplifier mode controller with apb control registers
`default_nettype none
module fe_mode_ctrl (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic radioReady,
  input wire logic radioDisabled,
  output logic txEn,
  output logic rxEn,
  output logic bypassSel,
  output logic antSel,
  output logic [31:0] transmitPowerSetting,
  output logic settleBusy
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    fe_ctrl_pkg::seq_t seq;
    fe_ctrl_pkg::fe_mode_t reqMode;
    fe_ctrl_pkg::fe_mode_t selMode;
    logic [1:0] links;
    logic staticOn;
    logic locked;
    logic regionEu;
    logic chan26;
    logic allowDir;
    logic [7:0] reqPower;
    logic [7:0] appliedPower;
    logic [fe_ctrl_pkg::SETTLE_W-1:0] settleCnt;
    fe_ctrl_pkg::fe_pins_t pins;
    logic [31:0] rdata;
    logic readyPrev;
    logic disPrev;
  } state_t;

  state_t s_q;
  state_t s_d;
  fe_ctrl_pkg::apb_req_t req;
  logic [1:0] evSync;
  logic readyEdge;
  logic disEdge;
  logic wrStrobe;
  logic rdSetup;
  logic mapped;
  logic [7:0] cap;
  fe_ctrl_pkg::fe_pins_t encPins;

  // a count that wraps its counter would end the settle wait early
  if (fe_ctrl_pkg::SETTLE_CYCLES < 1 || fe_ctrl_pkg::SETTLE_CYCLES >=
      (1 << fe_ctrl_pkg::SETTLE_W)) begin : g_settle_chk
    $error("settle counter too narrow");
  end

  // radio events come from another block's pins: synchronise first
  sync_2ff #(.WIDTH(2)) evSyncInst (
    .mclk(mclk),
    .rst_b(rst_b),
    .asyncIn({radioDisabled, radioReady}),
    .syncOut(evSync)
  );

  // ---------------------------------------------------------------
  // apb decode; zero-wait slave, read data is captured at setup
  // ---------------------------------------------------------------
  assign req = '{psel, penable, pwrite, paddr, pwdata};
  assign mapped = (req.paddr == fe_ctrl_pkg::CTRL_ADDR) ||
                  (req.paddr == fe_ctrl_pkg::POWER_ADDR) ||
                  (req.paddr == fe_ctrl_pkg::STATUS_ADDR) ||
                  (req.paddr == fe_ctrl_pkg::APPLIED_ADDR);
  assign wrStrobe = req.psel && req.penable && req.pwrite && mapped;
  assign rdSetup = req.psel && !req.penable && !req.pwrite;
  assign pready = 1'b1;
  assign pslverr = req.psel && req.penable && !mapped;
  assign readyEdge = evSync[0] && !s_q.readyPrev;
  assign disEdge = evSync[1] && !s_q.disPrev;

  // static pin pattern for the requested mode
  always_comb begin
    encPins = '0;
    case (s_q.reqMode)
      fe_ctrl_pkg::FRONT_END_TX_REQUEST: encPins.txEn = 1'b1;
      fe_ctrl_pkg::FRONT_END_RX_REQUEST: encPins.rxEn = 1'b1;
      fe_ctrl_pkg::FRONT_END_PASSTHROUGH_REQUEST: encPins.bypassSel = 1'b1;
      default: encPins = '0;
    endcase
  end

  // power cap: channel 26 tx in america gets a higher cap, and goes through bypass unless static
  always_comb begin
    if (!s_q.regionEu && s_q.chan26 &&
        s_q.reqMode == fe_ctrl_pkg::FRONT_END_TX_REQUEST)
      cap = fe_ctrl_pkg::CAP_CH26_BYPASS;
    else if (s_q.regionEu)
      cap = fe_ctrl_pkg::CAP_EUROPE;
    else
      cap = fe_ctrl_pkg::CAP_AMERICA;
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.readyPrev = evSync[0];
    s_d.disPrev = evSync[1];
    // signed compare keeps negative dBm codes ordered correctly
    if ($signed(s_q.reqPower) > $signed(cap))
      s_d.appliedPower = cap;
    else
      s_d.appliedPower = s_q.reqPower;

    // register writes; a write to control starts a mode change when idle and unlocked
    if (wrStrobe && req.paddr == fe_ctrl_pkg::POWER_ADDR)
      s_d.reqPower = req.pwdata[7:0];
    if (wrStrobe && req.paddr == fe_ctrl_pkg::CTRL_ADDR &&
        !s_q.locked && s_q.seq == fe_ctrl_pkg::SEQ_IDLE) begin
      s_d.reqMode = fe_ctrl_pkg::fe_mode_t'(
        req.pwdata[fe_ctrl_pkg::CTRL_MODE_LSB +: 2]);
      s_d.staticOn = req.pwdata[fe_ctrl_pkg::CTRL_STATIC_BIT];
      s_d.regionEu = req.pwdata[fe_ctrl_pkg::CTRL_EU_BIT];
      s_d.chan26 = req.pwdata[fe_ctrl_pkg::CTRL_CH26_BIT];
      s_d.allowDir = req.pwdata[fe_ctrl_pkg::CTRL_DIR_BIT];
      s_d.seq = fe_ctrl_pkg::SEQ_LINK_OFF;
    end

    case (s_q.seq)
      fe_ctrl_pkg::SEQ_IDLE: begin
        // event toggling serves every packet without software help
        if (s_q.links == fe_ctrl_pkg::LINK_MASK) begin
          if (disEdge)
            s_d.pins = '0;
          else if (readyEdge) begin
            // only the selected pin pulses, bypass included
            s_d.pins.txEn =
              s_q.selMode == fe_ctrl_pkg::FRONT_END_TX_REQUEST;
            s_d.pins.rxEn =
              s_q.selMode == fe_ctrl_pkg::FRONT_END_RX_REQUEST;
            s_d.pins.bypassSel = s_q.selMode ==
              fe_ctrl_pkg::FRONT_END_PASSTHROUGH_REQUEST;
          end
        end
      end
      fe_ctrl_pkg::SEQ_LINK_OFF: begin
        s_d.links = '0;
        s_d.seq = fe_ctrl_pkg::SEQ_FORCE_LOW;
      end
      fe_ctrl_pkg::SEQ_FORCE_LOW: begin
        // low first, so tx and rx never overlap across a change
        s_d.pins = '0;
        s_d.seq = fe_ctrl_pkg::SEQ_LOAD;
      end
      fe_ctrl_pkg::SEQ_LOAD: begin
        s_d.seq = fe_ctrl_pkg::SEQ_SETTLE;
        s_d.settleCnt = fe_ctrl_pkg::SETTLE_W'(fe_ctrl_pkg::SETTLE_CYCLES);
        if (s_q.staticOn) begin
          // static: direction modes only when explicitly allowed
          s_d.selMode = fe_ctrl_pkg::FRONT_END_OFF_REQUEST;
          s_d.locked = 1'b1;
          if (s_q.allowDir || s_q.reqMode ==
              fe_ctrl_pkg::FRONT_END_PASSTHROUGH_REQUEST)
            s_d.pins = encPins;
        end else if (s_q.reqMode == fe_ctrl_pkg::FRONT_END_OFF_REQUEST) begin
          s_d.selMode = fe_ctrl_pkg::FRONT_END_OFF_REQUEST;
        end else begin
          if (s_q.chan26 && !s_q.regionEu &&
              s_q.reqMode == fe_ctrl_pkg::FRONT_END_TX_REQUEST)
            s_d.selMode = fe_ctrl_pkg::FRONT_END_PASSTHROUGH_REQUEST;
          else
            s_d.selMode = s_q.reqMode;
          s_d.links = fe_ctrl_pkg::LINK_MASK;
        end
      end
      fe_ctrl_pkg::SEQ_SETTLE: begin
        // events wait until the front end has had time to switch
        s_d.settleCnt = s_q.settleCnt - 1'b1;
        if (s_q.settleCnt == fe_ctrl_pkg::SETTLE_W'(1))
          s_d.seq = fe_ctrl_pkg::SEQ_IDLE;
      end
      default: s_d.seq = fe_ctrl_pkg::SEQ_IDLE;
    endcase
    s_d.pins.antSel = 1'b0;

    // read data captured in the setup cycle
    s_d.rdata = '0;
    if (rdSetup) begin
      case (req.paddr)
        fe_ctrl_pkg::CTRL_ADDR:
          s_d.rdata[5:0] = {s_q.allowDir, s_q.chan26, s_q.regionEu,
                            s_q.staticOn, s_q.reqMode};
        fe_ctrl_pkg::POWER_ADDR: s_d.rdata[7:0] = s_q.reqPower;
        // status: locked, pins, links, busy, spare zero, selection
        fe_ctrl_pkg::STATUS_ADDR:
          s_d.rdata[10:0] = {s_q.locked, s_q.pins, s_q.links,
                             s_q.seq != fe_ctrl_pkg::SEQ_IDLE,
                             1'b0, s_q.selMode};
        fe_ctrl_pkg::APPLIED_ADDR: s_d.rdata[7:0] = s_q.appliedPower;
        default: s_d.rdata = '0;
      endcase
    end
  end

  // all pins low after reset: shutdown, external antenna
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      s_q <= '0;
      s_q.seq <= fe_ctrl_pkg::SEQ_IDLE;
      s_q.reqPower <= fe_ctrl_pkg::POWER_RESET;
      s_q.appliedPower <= fe_ctrl_pkg::POWER_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign txEn = s_q.pins.txEn;
  assign rxEn = s_q.pins.rxEn;
  assign bypassSel = s_q.pins.bypassSel;
  assign antSel = s_q.pins.antSel;
  assign prdata = s_q.rdata;
  assign transmitPowerSetting = {24'h000000, s_q.appliedPower};
  assign settleBusy = s_q.seq != fe_ctrl_pkg::SEQ_IDLE;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  // pin and power output patterns that must hold on every cycle
  a_pins_exclusive: assert property (
    @(posedge mclk) disable iff (!rst_b)
    $onehot0({txEn, rxEn, bypassSel}))
    else $error("more than one enable high");
  a_antsel_low: assert property (
    @(posedge mclk) disable iff (!rst_b)
    !antSel)
    else $error("antenna select driven high");
  a_power_high_zero: assert property (
    @(posedge mclk) disable iff (!rst_b)
    transmitPowerSetting[31:8] == 24'h000000)
    else $error("power setting upper bits set");
  // change sequence: links off, pin low, load, then settle
  a_link_off_order: assert property (
    @(posedge mclk) disable iff (!rst_b)
    s_q.seq == fe_ctrl_pkg::SEQ_LINK_OFF |=> s_q.links == '0 ##1
    ({txEn, rxEn, bypassSel} == 3'h0))
    else $error("links or pin not cleared in order");
  a_force_low: assert property (
    @(posedge mclk) disable iff (!rst_b)
    s_q.seq == fe_ctrl_pkg::SEQ_FORCE_LOW |=> s_q.pins == '0)
    else $error("pins not forced low");
  a_settle_wait: assert property (
    @(posedge mclk) disable iff (!rst_b)
    s_q.seq == fe_ctrl_pkg::SEQ_LOAD |=>
    (s_q.seq == fe_ctrl_pkg::SEQ_SETTLE)[*8] ##1
    (s_q.seq == fe_ctrl_pkg::SEQ_SETTLE)[*2] ##1
    s_q.seq == fe_ctrl_pkg::SEQ_IDLE)
    else $error("settle time not ten cycles");
  a_settle_quiet: assert property (
    @(posedge mclk) disable iff (!rst_b)
    s_q.seq == fe_ctrl_pkg::SEQ_SETTLE |=> $stable(s_q.pins))
    else $error("pins moved while settling");
  // event links: ready raises the selected pin, disabled drops all
  a_ready_raise: assert property (
    @(posedge mclk) disable iff (!rst_b)
    s_q.seq == fe_ctrl_pkg::SEQ_IDLE && s_q.links == fe_ctrl_pkg::LINK_MASK
    && readyEdge && !disEdge && !wrStrobe &&
    s_q.selMode == fe_ctrl_pkg::FRONT_END_TX_REQUEST |=> txEn)
    else $error("ready event did not raise pin");
  a_ready_rx: assert property (
    @(posedge mclk) disable iff (!rst_b)
    s_q.seq == fe_ctrl_pkg::SEQ_IDLE && s_q.links == fe_ctrl_pkg::LINK_MASK
    && readyEdge && !disEdge &&
    s_q.selMode == fe_ctrl_pkg::FRONT_END_RX_REQUEST |=> rxEn && !txEn)
    else $error("ready event did not raise receive pin");
  a_bypass_pulse: assert property (
    @(posedge mclk) disable iff (!rst_b)
    s_q.seq == fe_ctrl_pkg::SEQ_IDLE && s_q.links == fe_ctrl_pkg::LINK_MASK
    && readyEdge && !disEdge && s_q.selMode ==
    fe_ctrl_pkg::FRONT_END_PASSTHROUGH_REQUEST |=> bypassSel && !txEn)
    else $error("ready event did not pulse bypass");
  a_dis_lower: assert property (
    @(posedge mclk) disable iff (!rst_b)
    s_q.links == fe_ctrl_pkg::LINK_MASK && disEdge |=>
    ({txEn, rxEn, bypassSel} == 3'h0))
    else $error("disabled event did not lower pin");
  a_links_off_hold: assert property (
    @(posedge mclk) disable iff (!rst_b)
    s_q.seq == fe_ctrl_pkg::SEQ_IDLE &&
    s_q.links != fe_ctrl_pkg::LINK_MASK |=> $stable(s_q.pins))
    else $error("pins moved with links off");
  // power and mode selection
  a_power_cap: assert property (
    @(posedge mclk) disable iff (!rst_b)
    $stable(cap) && $stable(s_q.reqPower) |=>
    $signed(s_q.appliedPower) <= $signed($past(cap)))
    else $error("transmit power above cap");
  a_static_hold: assert property (
    @(posedge mclk) disable iff (!rst_b)
    s_q.locked && s_q.seq == fe_ctrl_pkg::SEQ_IDLE |=>
    $stable(s_q.pins))
    else $error("static pins changed");
  a_off_no_links: assert property (
    @(posedge mclk) disable iff (!rst_b)
    s_q.seq == fe_ctrl_pkg::SEQ_LOAD && !s_q.staticOn &&
    s_q.reqMode == fe_ctrl_pkg::FRONT_END_OFF_REQUEST |=>
    s_q.links == '0 && s_q.selMode == fe_ctrl_pkg::FRONT_END_OFF_REQUEST)
    else $error("shutdown left links on");
  a_ch26_bypass: assert property (
    @(posedge mclk) disable iff (!rst_b)
    s_q.seq == fe_ctrl_pkg::SEQ_LOAD && !s_q.staticOn && s_q.chan26 &&
    !s_q.regionEu && s_q.reqMode == fe_ctrl_pkg::FRONT_END_TX_REQUEST |=>
    s_q.selMode == fe_ctrl_pkg::FRONT_END_PASSTHROUGH_REQUEST)
    else $error("channel 26 not in bypass");
endmodule : fe_mode_ctrl
`default_nettype wire

/* File: sync_2ff.sv */
// two flip-flop synchroniser for asynchronous level inputs
`default_nettype none
module sync_2ff #(
  parameter int WIDTH = 2
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] meta_q;

  // ---------------------------------------------------------------
  // first stage feeds only the second
  // ---------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      meta_q <= '0;
      syncOut <= '0;
    end else begin
      meta_q <= asyncIn;
      syncOut <= meta_q;
    end
  end
endmodule : sync_2ff
`default_nettype wire

/* File: testbench.sv */
// self-checking bench for the front-end mode controller
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, transmitPowerSetting, rd;
  logic pready, pslverr, err, radioReady = 1'b0, radioDisabled = 1'b0;
  logic txEn, rxEn, bypassSel, antSel, settleBusy;
  logic [3:0] pins;
  fe_ctrl_pkg::fe_mode_t feMode;
  int mismatches = 0;
  int checks_done = 0;
  int seed = 32'h44a5;
  assign pins = {txEn, rxEn, bypassSel, antSel};
  initial begin
    forever #50 mclk = ~mclk;
  end
  fe_mode_ctrl uut (.mclk(mclk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .radioReady(radioReady), .radioDisabled(radioDisabled), .txEn(txEn),
    .rxEn(rxEn), .bypassSel(bypassSel), .antSel(antSel),
    .transmitPowerSetting(transmitPowerSetting), .settleBusy(settleBusy));
  fe_amp_model amp (.mclk(mclk), .txEn(txEn), .rxEn(rxEn),
    .bypassSel(bypassSel), .antSel(antSel), .feMode(feMode));
  // ---------------------------------------------------------------
  // report and helpers
  // ---------------------------------------------------------------
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : print_verdict
  task automatic chk(input string what, input logic [31:0] exp, got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic hang(input string what);
    mismatches++;
    $display("[ERR] %s expected done seen timeout", what);
    print_verdict();
  endtask : hang
  // sample on the falling edge so no race with the rising-edge updates
  task automatic ticks(input int n);
    repeat (n) @(negedge mclk);
  endtask : ticks
  // apb master: setup, then access held until pready is seen
  task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] d);
    int n;
    logic rdy;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    // ready, read data and error are all taken at the closing edge
    for (n = 0; n < 20; n++) begin
      @(posedge mclk);
      rdy = pready;
      rd = prdata;
      err = pslverr;
      if (rdy === 1'b1) break;
    end
    if (n == 20) hang("apb ready");
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic set_mode(input logic [31:0] w);
    int n;
    apb(1'b1, fe_ctrl_pkg::CTRL_ADDR, w);
    ticks(3);
    for (n = 0; n < 40 && settleBusy !== 1'b0; n++) ticks(1);
    if (n == 40) hang("settle");
  endtask : set_mode
  // dis selects the disabled event, otherwise the ready event
  task automatic pulse(input logic dis);
    @(posedge mclk);
    if (dis) radioDisabled <= 1'b1;
    else radioReady <= 1'b1;
    ticks(3);
    @(posedge mclk);
    if (dis) radioDisabled <= 1'b0;
    else radioReady <= 1'b0;
    ticks(12);
  endtask : pulse
  // one packet: selected pin from the ready event until the disabled event
  task automatic pkt(input logic [3:0] exp, fe_ctrl_pkg::fe_mode_t m);
    pulse(1'b0);
    chk("pins on ready", {28'h0, exp}, {28'h0, pins});
    chk("amp mode", {30'h0, m}, {30'h0, feMode});
    pulse(1'b1);
    chk("pins after disabled", 32'h0, {28'h0, pins});
  endtask : pkt
  task automatic do_reset;
    @(posedge mclk);
    rst_b <= 1'b0;
    ticks(2);
    @(posedge mclk);
    rst_b <= 1'b1;
  endtask : do_reset
  function automatic logic [31:0] capped(input logic [7:0] req,
      input logic eu, c26);
    logic [7:0] cap;
    cap = eu ? fe_ctrl_pkg::CAP_EUROPE :
      (c26 ? fe_ctrl_pkg::CAP_CH26_BYPASS : fe_ctrl_pkg::CAP_AMERICA);
    capped = ($signed(req) > $signed(cap)) ? {24'h0, cap} : {24'h0, req};
  endfunction : capped
  // never both enables, antenna select always low
  always @(negedge mclk) begin
    if (rst_b === 1'b1 && {txEn & rxEn, antSel} !== 2'b00) begin
      mismatches++;
      $display("[ERR] pin pair expected 0 seen %b", pins);
    end
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    logic [7:0] req;
    logic eu, c26;
    static logic [7:0] corner [4] = '{8'h7F, 8'h80, 8'hF8, 8'hF9};
    static logic [31:0] stat [3] = '{32'h5, 32'h25, 32'h7};
    static logic [3:0] spin [3] = '{4'h0, 4'h8, 4'h2};
    ticks(8);
    @(posedge mclk);
    rst_b <= 1'b1;
    ticks(1);
    chk("pins at init", 32'h0, {28'h0, pins});
    chk("power at init", 32'hF0, transmitPowerSetting);
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, err});
    chk("unmapped read", 32'h0, rd);
    for (int m = 0; m < 4; m++) begin
      set_mode(m);
      pkt(m == 0 ? 4'h0 : 4'(5'h10 >> m), fe_ctrl_pkg::fe_mode_t'(m));
      pkt(m == 0 ? 4'h0 : 4'(5'h10 >> m), fe_ctrl_pkg::fe_mode_t'(m));
    end
    set_mode(32'h1);
    @(posedge mclk);
    radioReady <= 1'b1;
    ticks(6);
    set_mode(32'h2);
    chk("pins after change", 32'h0, {28'h0, pins});
    @(posedge mclk);
    radioReady <= 1'b0;
    ticks(4);
    pkt(4'h4, fe_ctrl_pkg::FRONT_END_RX_REQUEST);
    for (int i = 0; i < 12; i++) begin
      eu = 1'($random(seed));
      c26 = 1'($random(seed));
      req = (i < 4) ? corner[i] : 8'($random(seed));
      set_mode({26'h0, 1'b0, c26, eu, 1'b0, 2'h1});
      apb(1'b1, fe_ctrl_pkg::POWER_ADDR, {24'h0, req});
      apb(1'b0, fe_ctrl_pkg::APPLIED_ADDR, 32'h0);
      chk("applied power", capped(req, eu, c26 & !eu), rd);
      chk("power out", capped(req, eu, c26 & !eu), transmitPowerSetting);
      apb(1'b0, fe_ctrl_pkg::POWER_ADDR, 32'h0);
      chk("power reg", {24'h0, req}, rd);
      if (c26 && !eu) begin
        pkt(4'h2, fe_ctrl_pkg::FRONT_END_PASSTHROUGH_REQUEST);
      end
    end
    for (int s = 0; s < 3; s++) begin
      do_reset();
      set_mode(stat[s]);
      chk("static pins", {28'h0, spin[s]}, {28'h0, pins});
      set_mode(32'h2);
      pulse(1'b1);
      chk("static locked", {28'h0, spin[s]}, {28'h0, pins});
      apb(1'b0, fe_ctrl_pkg::STATUS_ADDR, 32'h0);
      chk("status", {21'h0, 1'b1, spin[s], 6'h0}, rd);
      apb(1'b0, fe_ctrl_pkg::CTRL_ADDR, 32'h0);
      chk("ctrl reg", stat[s], rd);
    end
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
